// ===== shared/pmbus_target_consts.vh
// Constants for the power-management serial target block.
// Assumes a 200 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef PMBUS_TARGET_CONSTS_VH
`define PMBUS_TARGET_CONSTS_VH

// Clock and timing
`define CLK_PERIOD_NS 5
`define T_SEXT_MS 25
`define STRETCH_CYC 4'h8

// Register byte offsets
`define OFS_ALERT_MASK 8'h00
`define OFS_STATUS 8'h04
`define OFS_ADDR_STATE 8'h08
`define OFS_TELEM_EXP 8'h0c
`define OFS_CONV 8'h10

// Reset values
`define RST_ALERT_MASK 8'h00
`define RST_TELEM_EXP 5'h00
`define RST_OPERATION 8'h00
`define RST_ON_OFF_CFG 8'h16

// Bus commands
`define CMD_OPERATION 8'h01
`define CMD_ON_OFF_CFG 8'h02
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_VOUT_MODE 8'h20
`define CMD_READ_VIN 8'h88
`define CMD_READ_VOUT 8'h8b
`define CMD_READ_IOUT 8'h8c
`define CMD_READ_TEMP1 8'h8d
`define CMD_READ_TEMP2 8'h8e

// On/off configuration field positions
`define CFG_PU 4
`define CFG_CMD 3
`define CFG_CPR 2
`define CFG_POL 1
`define OP_ON 7

// Address strap default, status PEC bit, CRC polynomial and OPERATION on bit
`define ADDR_ZERO_STRAP 7'h40
`define STATUS_PEC_BIT 7
`define CRC_POLY 8'h07
`define OPERATION_ON_BIT 7

`endif

// ===== rtl/cmd_value_ram.v
// Command value store: one 16-bit word per command code.
// Single write port, registered read port on the same clock.
`timescale 1ns/1ps
module cmd_value_ram
(
  // Clock
  input wire hclk,
  // Write port
  input wire we,
  input wire [7:0] waddr,
  input wire [15:0] wdata,
  // Read port
  input wire [7:0] raddr,
  output reg [15:0] rdata
);
  reg [15:0] mem [0:255];

  always @(posedge hclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ===== rtl/pmbus_target_interface.v
// Power-management serial target: two-wire byte engine, PEC, clock stretch,
// alert masking, on/off gating, strap address latch and AHB-Lite registers.
// Assumes telemetry, faults and strap ADC results arrive on hclk.
// Function
// - Target side of the power-management bus, revision 1.3, over two wires.
// - Alert output asserts when new status information is present.
// - PEC byte generated on reads and checked on writes.
// - Device may hold SCL low to stretch the clock.
// - Accept more than sixty standard plus vendor commands.
// - SDA, SCL and alert are open drain only; never driven high.
// - After reset every fault and warning source can assert alert.
// - Per-condition mask stops masked sources pulling alert low.
// - Default: convert only while enable pin high; OPERATION ignored.
// - ON_OFF_CONFIG selects how pin and OPERATION decide on state.
// - READ_IOUT returns the filtered DC output current.
// - READ_VOUT returns measured output voltage.
// - READ_VIN returns measured input voltage.
// - TEMPERATURE_1 is power-train sum; TEMPERATURE_2 is controller die.
// - Telemetry uses LINEAR format, mantissa and exponent.
// - Output voltage values use the VOUT_MODE exponent.
// - Cumulative stretch per transaction never exceeds 25 ms.
// - Respond to one 7-bit address chosen by two straps.
// - Strap values converted at initialization select the address.
// - Strap sensing only during initialization; later changes ignored.
// - Address is high index times sixteen plus low; zero gives 0x40.
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "pmbus_target_consts.vh"
module pmbus_target_interface
#(
  parameter STRETCH_LIMIT_CYC = (`T_SEXT_MS * 1000000) / `CLK_PERIOD_NS
)
(
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Two-wire link pins
  input wire scl_i,
  output reg scl_o,
  output reg scl_oe,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe,
  // Alert pin
  output reg alert_out_pin_o,
  output reg alert_out_pin_oe,
  // Enable control pin and converter gate
  input wire ctrl_pin,
  output reg conv_on,
  // Strap sensing
  input wire init_active,
  input wire strap_sample,
  input wire [3:0] strap_resistor_low_idx,
  input wire [3:0] strap_resistor_high_idx,
  output reg strap_sense_en,
  // Telemetry and fault sources
  input wire [15:0] vout_value,
  input wire [10:0] vin_mant,
  input wire [10:0] iout_filt_mant,
  input wire [10:0] temp_train_sum_mant,
  input wire [10:0] temp_ctrl_mant,
  input wire [6:0] fault_in
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_ACKA = 7'h04;
  localparam [6:0] S_RX = 7'h08;
  localparam [6:0] S_ACKR = 7'h10;
  localparam [6:0] S_TX = 7'h20;
  localparam [6:0] S_ACKM = 7'h40;
  localparam [22:0] EXT_LIMIT = STRETCH_LIMIT_CYC[22:0];

  function [7:0] crc8;
    input [7:0] c;
    input [7:0] d;
    integer i;
    reg [7:0] x;
    begin
      x = c ^ d;
      for (i = 0; i < 8; i = i + 1)
      begin
        x = x[7] ? ((x << 1) ^ `CRC_POLY) : (x << 1);
      end
      crc8 = x;
    end
  endfunction

  // Synchronisers
  reg [2:0] scl_sy;
  reg [2:0] sda_sy;
  reg [1:0] ctrl_sy;
  wire scl_rise = scl_sy[1] & ~scl_sy[2];
  wire scl_fall = ~scl_sy[1] & scl_sy[2];
  wire start_ev = scl_sy[1] & sda_sy[2] & ~sda_sy[1];
  wire stop_ev = scl_sy[1] & ~sda_sy[2] & sda_sy[1];

  // Link engine state
  reg [6:0] state;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg [7:0] txsh;
  reg rw;
  reg in_txn;
  reg have_cmd;
  reg [7:0] cmd;
  reg [2:0] nbyte;
  reg [2:0] txcnt;
  reg [15:0] wbuf;
  reg pec_ok;
  reg [7:0] crc;
  reg [3:0] stretch_cnt;
  reg [22:0] ext_cnt;
  reg mem_we;
  reg [15:0] mem_rdata_w;
  wire [15:0] mem_rdata;

  // Control and status
  reg [7:0] operation;
  reg [7:0] on_off_cfg;
  reg [7:0] alert_mask;
  reg [7:0] status;
  reg [4:0] telem_exp;
  reg [6:0] dev_addr;
  reg addr_latched;
  reg clear_faults;
  reg pec_err;

  // AHB data phase
  reg dp_wr;
  reg [7:0] dp_addr;

  wire [2:0] cmd_len = (cmd[7:5] == 3'h0) ? 3'h1 : 3'h2;

  cmd_value_ram u_ram
  (
    .hclk(hclk),
    .we(mem_we),
    .waddr(cmd),
    .wdata(wbuf),
    .raddr(cmd),
    .rdata(mem_rdata)
  );

  // Read word selection
  always @*
  begin
    case (cmd)
      `CMD_READ_VOUT: mem_rdata_w = vout_value;
      `CMD_READ_VIN: mem_rdata_w = {telem_exp, vin_mant};
      `CMD_READ_IOUT: mem_rdata_w = {telem_exp, iout_filt_mant};
      `CMD_READ_TEMP1: mem_rdata_w = {telem_exp, temp_train_sum_mant};
      `CMD_READ_TEMP2: mem_rdata_w = {telem_exp, temp_ctrl_mant};
      `CMD_OPERATION: mem_rdata_w = {8'h00, operation};
      `CMD_ON_OFF_CFG: mem_rdata_w = {8'h00, on_off_cfg};
      default: mem_rdata_w = mem_rdata;
    endcase
  end

  // Next byte to send; PEC follows the data bytes
  reg [7:0] tx_next;
  always @*
  begin
    if (txcnt < cmd_len)
    begin
      tx_next = (txcnt == 3'h0) ? mem_rdata_w[7:0] : mem_rdata_w[15:8];
    end
    else if (txcnt == cmd_len)
    begin
      tx_next = crc;
    end
    else
    begin
      tx_next = 8'hff;
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_sy <= 3'h7;
      sda_sy <= 3'h7;
      ctrl_sy <= 2'h0;
    end
    else
    begin
      scl_sy <= {scl_sy[1:0], scl_i};
      sda_sy <= {sda_sy[1:0], sda_i};
      ctrl_sy <= {ctrl_sy[0], ctrl_pin};
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= S_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txsh <= 8'h00;
      rw <= 1'b0;
      in_txn <= 1'b0;
      have_cmd <= 1'b0;
      cmd <= 8'h00;
      nbyte <= 3'h0;
      txcnt <= 3'h0;
      wbuf <= 16'h0000;
      pec_ok <= 1'b0;
      crc <= 8'h00;
      sda_oe <= 1'b0;
      stretch_cnt <= 4'h0;
      mem_we <= 1'b0;
      operation <= `RST_OPERATION;
      on_off_cfg <= `RST_ON_OFF_CFG;
      clear_faults <= 1'b0;
      pec_err <= 1'b0;
    end
    else
    begin
      mem_we <= 1'b0;
      clear_faults <= 1'b0;
      pec_err <= 1'b0;
      if (stretch_cnt != 4'h0)
      begin
        stretch_cnt <= stretch_cnt - 4'h1;
      end
      if (stop_ev)
      begin
        state <= S_IDLE;
        sda_oe <= 1'b0;
        in_txn <= 1'b0;
        have_cmd <= 1'b0;
        if (in_txn && !rw && have_cmd)
        begin
          // Write with bad PEC is discarded
          if (nbyte == cmd_len + 3'h1 && !pec_ok)
          begin
            pec_err <= 1'b1;
          end
          else if (cmd == `CMD_CLEAR_FAULTS)
          begin
            clear_faults <= 1'b1;
          end
          else if (nbyte == cmd_len || nbyte == cmd_len + 3'h1)
          begin
            if (cmd == `CMD_OPERATION)
            begin
              operation <= wbuf[7:0];
            end
            else if (cmd == `CMD_ON_OFF_CFG)
            begin
              on_off_cfg <= wbuf[7:0];
            end
            else
            begin
              mem_we <= 1'b1;
            end
          end
        end
      end
      else if (start_ev)
      begin
        state <= S_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
        in_txn <= 1'b1;
        if (!in_txn)
        begin
          crc <= 8'h00;
        end
      end
      else if (scl_rise)
      begin
        if ((state == S_ADDR || state == S_RX) && bitcnt != 4'h8)
        begin
          shreg <= {shreg[6:0], sda_sy[1]};
          bitcnt <= bitcnt + 4'h1;
        end
        else if (state == S_ACKM && sda_sy[1])
        begin
          state <= S_IDLE;
        end
      end
      else if (scl_fall)
      begin
        case (state)
          S_ADDR:
          begin
            if (bitcnt == 4'h8)
            begin
              if (addr_latched && shreg[7:1] == dev_addr)
              begin
                state <= S_ACKA;
                sda_oe <= 1'b1;
                rw <= shreg[0];
                txcnt <= 3'h0;
                crc <= crc8(crc, shreg);
              end
              else
              begin
                state <= S_IDLE;
              end
            end
          end
          S_RX:
          begin
            if (bitcnt == 4'h8)
            begin
              state <= S_ACKR;
              sda_oe <= 1'b1;
              crc <= crc8(crc, shreg);
              if (!have_cmd)
              begin
                cmd <= shreg;
                have_cmd <= 1'b1;
                nbyte <= 3'h0;
                pec_ok <= 1'b0;
              end
              else
              begin
                if (nbyte == 3'h0)
                begin
                  wbuf <= {8'h00, shreg};
                end
                if (nbyte == 3'h1)
                begin
                  wbuf[15:8] <= shreg;
                end
                if (nbyte == cmd_len)
                begin
                  pec_ok <= (shreg == crc);
                end
                if (nbyte != 3'h7)
                begin
                  nbyte <= nbyte + 3'h1;
                end
              end
            end
          end
          S_ACKR:
          begin
            state <= S_RX;
            bitcnt <= 4'h0;
            sda_oe <= 1'b0;
          end
          S_ACKA, S_ACKM:
          begin
            if (state == S_ACKA && !rw)
            begin
              state <= S_RX;
              bitcnt <= 4'h0;
              sda_oe <= 1'b0;
            end
            else
            begin
              // Hold SCL while the first reply byte is staged
              if (state == S_ACKA)
              begin
                stretch_cnt <= `STRETCH_CYC;
              end
              // PEC generated across the whole transaction
              state <= S_TX;
              txsh <= {tx_next[6:0], 1'b0};
              sda_oe <= ~tx_next[7];
              crc <= crc8(crc, tx_next);
              bitcnt <= 4'h1;
              txcnt <= (txcnt == 3'h7) ? txcnt : txcnt + 3'h1;
            end
          end
          S_TX:
          begin
            if (bitcnt == 4'h8)
            begin
              state <= S_ACKM;
              sda_oe <= 1'b0;
            end
            else
            begin
              sda_oe <= ~txsh[7];
              txsh <= {txsh[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end
          end
          default:
          begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_cnt <= 23'h0;
      scl_oe <= 1'b0;
    end
    else
    begin
      if ((start_ev && !in_txn) || stop_ev)
      begin
        ext_cnt <= 23'h0;
      end
      else if (scl_oe)
      begin
        ext_cnt <= ext_cnt + 23'h1;
      end
      // The host is expected to wait out this low phase
      scl_oe <= (stretch_cnt > 4'h1) && (ext_cnt < EXT_LIMIT - 23'h1);
    end
  end

  // Strap address latch, once, at initialization
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dev_addr <= `ADDR_ZERO_STRAP;
      addr_latched <= 1'b0;
      strap_sense_en <= 1'b0;
    end
    else
    begin
      strap_sense_en <= init_active && !addr_latched;
      if (init_active && strap_sample && !addr_latched)
      begin
        addr_latched <= 1'b1;
        // 7-bit address from two strap indices
        if (strap_resistor_high_idx == 4'h0 && strap_resistor_low_idx == 4'h0)
        begin
          dev_addr <= `ADDR_ZERO_STRAP;
        end
        else
        begin
          dev_addr <= {strap_resistor_high_idx[2:0], strap_resistor_low_idx};
        end
      end
    end
  end

  // Status, alert and converter gate; AHB-Lite slave
  wire ahb_take = hsel && hready && htrans[1];
  reg [31:0] rd_mux;
  always @*
  begin
    case (haddr[7:0])
      `OFS_ALERT_MASK: rd_mux = {24'h0, alert_mask};
      `OFS_STATUS: rd_mux = {24'h0, status};
      `OFS_ADDR_STATE: rd_mux = {24'h0, addr_latched, dev_addr};
      `OFS_TELEM_EXP: rd_mux = {27'h0, telem_exp};
      `OFS_CONV: rd_mux = {15'h0, conv_on, operation, on_off_cfg};
      default: rd_mux = 32'h0;
    endcase
  end

  wire sw_clr = dp_wr && dp_addr == `OFS_STATUS;
  wire [7:0] w1c = sw_clr ? hwdata[7:0] : 8'h00;
  wire [7:0] events = {pec_err, fault_in};
  wire ctl_ok = ~on_off_cfg[`CFG_CMD] | operation[`OP_ON];
  wire pin_ok = ~on_off_cfg[`CFG_CPR] | (ctrl_sy[1] == on_off_cfg[`CFG_POL]);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
      alert_mask <= `RST_ALERT_MASK;
      telem_exp <= `RST_TELEM_EXP;
      status <= 8'h00;
      alert_out_pin_oe <= 1'b0;
      alert_out_pin_o <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      conv_on <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dp_wr <= ahb_take && hwrite;
      dp_addr <= haddr[7:0];
      if (ahb_take && !hwrite)
      begin
        hrdata <= rd_mux;
      end
      if (dp_wr && dp_addr == `OFS_ALERT_MASK)
      begin
        alert_mask <= hwdata[7:0];
      end
      if (dp_wr && dp_addr == `OFS_TELEM_EXP)
      begin
        telem_exp <= hwdata[4:0];
      end
      // Set wins over either clear
      status <= events | (status & ~w1c & {8{~clear_faults}});
      alert_out_pin_oe <= |(status & ~alert_mask);
      // Open-drain outputs only ever pull low
      alert_out_pin_o <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      conv_on <= on_off_cfg[`CFG_PU] ? (ctl_ok & pin_ok) : 1'b1;
    end
  end
endmodule

// ===== tb/pmbus_host_model.sv
// Host controller model: bit-bangs SCL and SDA at a 48 ns bit period.
// Assumes pull-ups on both wires; the bench resolves the wire levels.
`timescale 1ns/1ps
module pmbus_host_model
(
  // Wire levels
  input wire scl,
  input wire sda,
  // Open-drain pulls, high pulls the wire low
  output reg scl_low,
  output reg sda_low
);
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task bit_io(input b, output r);
  begin
    #8 sda_low = !b;
    #16 scl_low = 1'b0;
    wait (scl === 1'b1);
    #12 r = sda;
    #12 scl_low = 1'b1;
  end
  endtask
  task start;
  begin
    #8 sda_low = 1'b0;
    #16 scl_low = 1'b0;
    wait (scl === 1'b1);
    #24 sda_low = 1'b1;
    #24 scl_low = 1'b1;
  end
  endtask
  // Clock is left standing high after stop
  task stop;
  begin
    #8 sda_low = 1'b1;
    #16 scl_low = 1'b0;
    wait (scl === 1'b1);
    #24 sda_low = 1'b0;
    #48;
  end
  endtask
  // byte MSB first, then ack bit
  task xfer(input [7:0] wb, input ab, output [7:0] rb, output ak);
    integer i;
    reg r;
  begin
    for (i = 7; i >= 0; i = i - 1)
    begin
      bit_io(wb[i], r);
      rb[i] = r;
    end
    bit_io(ab, ak);
  end
  endtask
endmodule

// ===== tb/pmbus_target_interface_assertions.sv
// Concurrent checks on the target block's pins and strap sensing.
// Assumes one hclk domain and pull-ups on both wires.
`timescale 1ns/1ps
module pmbus_target_interface_assertions
#(
  parameter STRETCH_LIMIT_CYC = 20
)
(
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Bus response
  input wire hreadyout,
  input wire hresp,
  // Link pins
  input wire scl_i,
  input wire scl_o,
  input wire scl_oe,
  input wire sda_o,
  input wire sda_oe,
  input wire alert_out_pin_o,
  // Strap sensing
  input wire init_active,
  input wire strap_sample,
  input wire strap_sense_en
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Consecutive stretch length; a cheap stand-in for the cumulative figure
  reg [31:0] held;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      held <= 32'h0;
    else
      held <= scl_oe ? held + 32'h1 : 32'h0;
  sequence s_ack_held;
    sda_oe [*4];
  endsequence
  a_open_drain: assert property (!scl_o && !sda_o && !alert_out_pin_o)
    else $error("pin driven high");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  a_stretch_pulls: assert property (scl_oe |-> !scl_i)
    else $error("stretch without low clock");
  a_stretch_cap: assert property (held <= STRETCH_LIMIT_CYC)
    else $error("stretch too long");
  a_sda_on_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data moved with clock high");
  a_ack_held: assert property ($rose(sda_oe) |-> s_ack_held)
    else $error("data pull too short");
  a_sense_init: assert property (strap_sense_en |-> $past(init_active))
    else $error("sensing outside init");
  a_sense_once: assert property (strap_sample && strap_sense_en |-> ##[1:2] !strap_sense_en)
    else $error("sensing kept after latch");
endmodule
bind pmbus_target_interface pmbus_target_interface_assertions
  #(.STRETCH_LIMIT_CYC(STRETCH_LIMIT_CYC)) u_chk (.hclk, .hresetn, .hreadyout, .hresp,
  .scl_i, .scl_o, .scl_oe, .sda_o, .sda_oe, .alert_out_pin_o, .init_active,
  .strap_sample, .strap_sense_en);

// ===== tb/pmbus_target_interface_test.sv
// Self-checking bench: AHB-Lite master tasks plus a two-wire host model.
// Assumes hclk at 200 MHz and a stretch limit of 5 cycles, short enough to cut a stretch.
`timescale 1ns/1ps
`include "pmbus_target_consts.vh"
module pmbus_target_interface_test;
  reg hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ctrl_pin = 1'b0;
  reg init_active = 1'b1, strap_sample = 1'b0;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  reg [1:0] htrans = 2'h0;
  reg [2:0] hsize = 3'h2;
  reg [3:0] strap_resistor_low_idx = 4'h6, strap_resistor_high_idx = 4'h5;
  reg [15:0] vout_value = 16'h0;
  reg [10:0] vin_mant = 11'h0, iout_filt_mant = 11'h0;
  reg [10:0] temp_train_sum_mant = 11'h0, temp_ctrl_mant = 11'h0;
  reg [6:0] fault_in = 7'h0, dev = 7'h56;
  reg [7:0] pec, lo, hi, e, p;
  reg [39:0] rows [0:4];
  integer failures = 0, n_checks = 0, i;
  wire [31:0] hrdata;
  wire hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, alert_out_pin_o, alert_out_pin_oe;
  wire conv_on, strap_sense_en, h_scl_low, h_sda_low;
  wire hready = hreadyout;
  wire scl_i = (scl_oe ? scl_o : 1'b1) & !h_scl_low;
  wire sda_i = (sda_oe ? sda_o : 1'b1) & !h_sda_low;
  always #2.5 hclk = !hclk;
  pmbus_target_interface #(.STRETCH_LIMIT_CYC(5)) u_dut (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .scl_i, .scl_o,
    .scl_oe, .sda_i, .sda_o, .sda_oe, .alert_out_pin_o, .alert_out_pin_oe, .ctrl_pin, .conv_on,
    .init_active, .strap_sample, .strap_resistor_low_idx, .strap_resistor_high_idx,
    .strap_sense_en, .vout_value, .vin_mant, .iout_filt_mant, .temp_train_sum_mant,
    .temp_ctrl_mant, .fault_in);
  pmbus_host_model u_host (.scl(scl_i), .sda(sda_i), .scl_low(h_scl_low), .sda_low(h_sda_low));
  function [7:0] crc8(input [7:0] c, input [7:0] b);
    integer k;
  begin
    crc8 = c ^ b;
    for (k = 0; k < 8; k = k + 1)
      crc8 = crc8[7] ? {crc8[6:0], 1'b0} ^ `CRC_POLY : {crc8[6:0], 1'b0};
  end
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task tally_and_finish;
  begin
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task ahb(input w, input [7:0] a, input [31:0] d);
  begin
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  end
  endtask
  task rchk(input [7:0] a, input [31:0] exp);
  begin
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  end
  endtask
  task put(input [7:0] b, input nak);
    reg [7:0] r;
    reg k;
  begin
    u_host.xfer(b, 1'b1, r, k);
    pec = crc8(pec, b);
    chk({31'h0, k}, {31'h0, nak});
  end
  endtask
  task get(input last, output [7:0] r);
    reg k;
  begin
    u_host.xfer(8'hff, last, r, k);
    pec = crc8(pec, r);
  end
  endtask
  task pm_wr(input [7:0] cmd, input [15:0] d, input [7:0] bad);
  begin
    pec = 8'h00;
    u_host.start;
    put({dev, 1'b0}, 1'b0);
    put(cmd, 1'b0);
    put(d[7:0], 1'b0);
    // Word commands carry a second data byte, low byte first
    if (cmd >= 8'h20)
      put(d[15:8], 1'b0);
    put(pec ^ bad, 1'b0);
    u_host.stop;
  end
  endtask
  task pm_rd(input [7:0] cmd, input [15:0] exp);
  begin
    pec = 8'h00;
    u_host.start;
    put({dev, 1'b0}, 1'b0);
    put(cmd, 1'b0);
    u_host.start;
    put({dev, 1'b1}, 1'b0);
    get(1'b0, lo);
    get(1'b0, hi);
    e = pec;
    get(1'b1, p);
    u_host.stop;
    chk({hi, lo}, exp);
    chk(p, e);
  end
  endtask
  task fault(input [6:0] f);
  begin
    @(posedge hclk) fault_in <= f;
    @(posedge hclk) fault_in <= 7'h0;
    repeat (4) @(posedge hclk);
  end
  endtask
  initial
  begin
    #300000;
    failures = failures + 1;
    tally_and_finish;
  end
  initial
  begin
    rows[0] = {8'h88, 16'h0123, 16'hd923};
    rows[1] = {8'h8b, 16'h1ccd, 16'h1ccd};
    rows[2] = {8'h8c, 16'h00a5, 16'hd8a5};
    rows[3] = {8'h8d, 16'h031c, 16'hdb1c};
    rows[4] = {8'h8e, 16'h007e, 16'hd87e};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk) strap_sample <= 1'b1;
    @(posedge hclk) strap_sample <= 1'b0;
    init_active <= 1'b0;
    repeat (4) @(posedge hclk);
    strap_resistor_low_idx <= 4'h0;
    strap_resistor_high_idx <= 4'h0;
    strap_sample <= 1'b1;
    @(posedge hclk) strap_sample <= 1'b0;
    rchk(`OFS_ADDR_STATE, 32'hd6);
    chk({31'h0, strap_sense_en}, 32'h0);
    rchk(`OFS_ALERT_MASK, 32'h0);
    rchk(`OFS_CONV, 32'h16);
    rchk(8'h24, 32'h0);
    ahb(1'b1, `OFS_TELEM_EXP, 32'h1b);
    for (i = 0; i < 5; i = i + 1)
    begin
      @(posedge hclk) vout_value <= rows[i][31:16];
      vin_mant <= rows[i][26:16];
      iout_filt_mant <= rows[i][26:16];
      temp_train_sum_mant <= rows[i][26:16];
      temp_ctrl_mant <= rows[i][26:16];
      pm_rd(rows[i][39:32], rows[i][15:0]);
    end
    pec = 8'h00;
    u_host.start;
    put({7'h57, 1'b0}, 1'b1);
    u_host.stop;
    @(posedge hclk) ctrl_pin <= 1'b1;
    pm_wr(`CMD_OPERATION, 16'h0000, 8'h00);
    chk({31'h0, conv_on}, 32'h1);
    @(posedge hclk) ctrl_pin <= 1'b0;
    repeat (6) @(posedge hclk);
    chk({31'h0, conv_on}, 32'h0);
    pm_wr(`CMD_ON_OFF_CFG, 16'h0018, 8'h00);
    pm_wr(`CMD_OPERATION, 16'h0080, 8'h00);
    repeat (4) @(posedge hclk);
    rchk(`OFS_CONV, 32'h18018);
    pm_wr(`CMD_OPERATION, 16'h0000, 8'h5a);
    repeat (4) @(posedge hclk);
    chk({31'h0, conv_on}, 32'h1);
    rchk(`OFS_STATUS, 32'h80);
    chk({31'h0, alert_out_pin_oe}, 32'h1);
    ahb(1'b1, `OFS_STATUS, 32'hff);
    repeat (2) @(posedge hclk);
    chk({31'h0, alert_out_pin_oe}, 32'h0);
    fault(7'h04);
    chk({31'h0, alert_out_pin_oe}, 32'h1);
    ahb(1'b1, `OFS_STATUS, 32'h04);
    ahb(1'b1, `OFS_ALERT_MASK, 32'h04);
    fault(7'h04);
    chk({31'h0, alert_out_pin_oe}, 32'h0);
    rchk(`OFS_STATUS, 32'h04);
    pec = 8'h00;
    u_host.start;
    put({dev, 1'b0}, 1'b0);
    put(`CMD_CLEAR_FAULTS, 1'b0);
    u_host.stop;
    repeat (4) @(posedge hclk);
    rchk(`OFS_STATUS, 32'h0);
    pm_wr(8'h21, 16'h1a2b, 8'h00);
    pm_rd(8'h21, 16'h1a2b);
    @(posedge hclk) hresetn <= 1'b0;
    init_active <= 1'b1;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk) strap_sample <= 1'b1;
    @(posedge hclk) strap_sample <= 1'b0;
    init_active <= 1'b0;
    rchk(`OFS_ADDR_STATE, 32'hc0);
    rchk(`OFS_TELEM_EXP, 32'h0);
    tally_and_finish;
  end
endmodule
